// File: sim/eiec_core_model.sv
module eiec_core_model
(
    input  wire logic       sys_clk,     // system clock
    input  wire logic       sys_rst,     // async reset, high
    input  wire logic [3:0] vec_req,     // pdw, svd, high, low vector requests
    input  wire logic       wake_event,  // event wake pulse
    input  wire logic       sev_on_pend, // send_event_on_pending in the core
    input  wire logic [3:0] core_en,     // core-side vector enables
    input  wire logic       core_clr,    // software clears core pending bits
    output logic      [3:0] core_pend,   // core pending bits
    output int              wake_cnt     // wake-ups from wait_for_event
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] masked_q;

    // -------------------------------------------------
    // core pending and wake-up
    // -------------------------------------------------
    // a masked vector only wakes on its rise, so one request is one wake-up
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            masked_q  <= 4'h0;
            core_pend <= 4'h0;
            wake_cnt  <= 0;
        end
        else
        begin
            masked_q  <= vec_req & ~core_en;
            core_pend <= core_clr ? 4'h0 : (core_pend | vec_req);
            if (wake_event || (sev_on_pend && |(vec_req & ~core_en & ~masked_q)))
                wake_cnt <= wake_cnt + 1;
        end
    end
endmodule

// File: sim/external_interrupt_event_ctrl_tb_top.sv
`include "eiec_cfg.svh"

module external_interrupt_event_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk;
    logic        sys_rst;
    logic        hsel;
    logic        hwrite;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout;
    logic        hresp;
    logic [15:0] port_pin;
    logic        svd_in;
    logic        auto_wake_in;
    logic        pdw_in;
    logic [3:0]  vec;
    logic        wake_event;
    logic        sev;
    logic [3:0]  core_en;
    logic        core_clr;
    logic [3:0]  core_pend;
    int          wake_cnt;
    int          n_errors;
    int          cmp_count;
    int          cycles;

    eiec_top #(.LINES(`EIEC_NUM_LINES)) i_dut
    (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .port_pin(port_pin), .supply_voltage_detect(svd_in),
        .auto_wakeup(auto_wake_in), .power_delivery_wake(pdw_in), .low_pin_group_vector(vec[0]),
        .high_pin_group_vector(vec[1]), .svd_vector(vec[2]), .pdw_vector(vec[3]), .wake_event(wake_event)
    );

    eiec_core_model i_core
    (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .vec_req(vec), .wake_event(wake_event), .sev_on_pend(sev),
        .core_en(core_en), .core_clr(core_clr), .core_pend(core_pend), .wake_cnt(wake_cnt)
    );

    // -------------------------------------------------
    // bus master and checking
    // -------------------------------------------------
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wdata, output logic [31:0] rdata);
        @(posedge sys_clk);
        check("hreadyout idle", {31'h0, hreadyout}, 32'h1);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, ofs};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= 3'b010;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wdata;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rdata = hrdata;
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask

    task wr(input logic [7:0] ofs, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, ofs, d, x);
    endtask

    task rd_chk(input string what, input logic [7:0] ofs, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, ofs, 32'h0, x);
        check(what, x, exp);
    endtask

    // waits a bounded time for the vectors, then compares them
    task wait_vec(input logic [3:0] exp);
        int i;
        for (i = 0; i < 20 && vec !== exp; i++)
            @(posedge sys_clk);
        check("vectors", {28'h0, vec}, {28'h0, exp});
    endtask

    // -------------------------------------------------
    // scenarios
    // -------------------------------------------------
    task t_regs;
        logic [7:0] o;
        for (o = 8'h00; o < 8'h18; o += 8'h04)
            rd_chk("reset value", o, 32'h0);
        for (o = 8'h00; o < 8'h10; o += 8'h04)
        begin
            wr(o, 32'hffffffff);
            rd_chk("mask readback", o, 32'h0007ffff);
            wr(o, 32'h0);
        end
        wr(8'h18, 32'hffffffff);
        rd_chk("unmapped", 8'h18, 32'h0);
    endtask

    task t_edges;
        wr(`EIEC_OFS_INT_MASK, 32'h00010208);
        wr(`EIEC_OFS_RISE_EN, 32'h00010008);
        wr(`EIEC_OFS_FALL_EN, 32'h00010200);
        port_pin[3] <= 1'b1;
        wait_vec(4'h1);
        rd_chk("pend rise", `EIEC_OFS_PEND, 32'h8);
        wr(`EIEC_OFS_PEND, 32'h0);
        rd_chk("pend kept", `EIEC_OFS_PEND, 32'h8);
        wr(`EIEC_OFS_PEND, 32'h8);
        rd_chk("pend cleared", `EIEC_OFS_PEND, 32'h0);
        port_pin[3] <= 1'b0;
        port_pin[9] <= 1'b1;
        repeat (10) @(posedge sys_clk);
        rd_chk("edge not enabled", `EIEC_OFS_PEND, 32'h0);
        port_pin[9] <= 1'b0;
        wait_vec(4'h2);
        rd_chk("pend fall", `EIEC_OFS_PEND, 32'h200);
        wr(`EIEC_OFS_PEND, 32'h200);
        svd_in <= 1'b1;
        wait_vec(4'h4);
        wr(`EIEC_OFS_PEND, 32'h10000);
        svd_in <= 1'b0;
        wait_vec(4'h0);
        wait_vec(4'h4);
        wr(`EIEC_OFS_PEND, 32'h10000);
        wait_vec(4'h0);
    endtask

    task t_swtrig;
        int         lines[7] = '{0, 7, 8, 15, 16, 17, 18};
        logic [3:0] exps[7] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h4, 4'h0, 4'h8};
        int         k;
        wr(`EIEC_OFS_INT_MASK, 32'h0007ffff);
        for (k = 0; k < 7; k++)
        begin
            wr(`EIEC_OFS_SW_TRIG, 32'h1 << lines[k]);
            wait_vec(exps[k]);
            rd_chk("sw pend", `EIEC_OFS_PEND, 32'h1 << lines[k]);
            rd_chk("sw bits", `EIEC_OFS_SW_TRIG, 32'h1 << lines[k]);
            wr(`EIEC_OFS_PEND, 32'h1 << lines[k]);
            wait_vec(4'h0);
        end
    endtask

    task t_event;
        int n0;
        wr(`EIEC_OFS_INT_MASK, 32'h00000010);
        wr(`EIEC_OFS_EVT_MASK, 32'h00060010);
        wr(`EIEC_OFS_RISE_EN, 32'h00060000);
        n0 = wake_cnt;
        pdw_in <= 1'b1;
        repeat (12) @(posedge sys_clk);
        check("edge wake", wake_cnt - n0, 32'h1);
        auto_wake_in <= 1'b1;
        repeat (12) @(posedge sys_clk);
        check("auto wake", wake_cnt - n0, 32'h2);
        rd_chk("event leaves no flag", `EIEC_OFS_PEND, 32'h0);
        wr(`EIEC_OFS_SW_TRIG, 32'h10);
        repeat (3) @(posedge sys_clk);
        check("sw wake", wake_cnt - n0, 32'h3);
        wait_vec(4'h1);
        wr(`EIEC_OFS_PEND, 32'h10);
        wr(`EIEC_OFS_EVT_MASK, 32'h0);
        wr(`EIEC_OFS_INT_MASK, 32'h1);
        core_en <= 4'he;
        sev     <= 1'b1;
        n0 = wake_cnt;
        wr(`EIEC_OFS_SW_TRIG, 32'h1);
        repeat (3) @(posedge sys_clk);
        check("pending wake", wake_cnt - n0, 32'h1);
        wr(`EIEC_OFS_PEND, 32'h1);
        core_clr <= 1'b1;
        @(posedge sys_clk);
        core_clr <= 1'b0;
        @(posedge sys_clk);
        check("core pend", {28'h0, core_pend}, 32'h0);
        wait_vec(4'h0);
    endtask

    task finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // -------------------------------------------------
    // clock, timeout and main sequence
    // -------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            finish_test();
        end
    end

    initial
    begin
        {hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
        {port_pin, svd_in, auto_wake_in, pdw_in, sev, core_clr} = '0;
        core_en = 4'hf;
        sys_rst = 1'b1;
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_edges();
        t_swtrig();
        t_event();
        finish_test();
    end
endmodule

// File: verilog/eiec_bus.sv
`include "eiec_cfg.svh"

module eiec_bus
(
    input  wire logic        sys_clk,    // system clock
    input  wire logic        sys_rst,    // async reset, high
    input  wire logic        hsel,       // slave select
    input  wire logic [31:0] haddr,      // byte address
    input  wire logic [1:0]  htrans,     // transfer type
    input  wire logic        hwrite,     // write
    input  wire logic [2:0]  hsize,      // transfer size
    input  wire logic        hready,     // bus ready in
    output logic             wr_en,      // data-phase write strobe
    output logic             rd_en,      // address-phase read take
    output eiec_pkg::eiec_reg_e wr_reg,  // register of the write
    output eiec_pkg::eiec_reg_e rd_reg   // register being read
);

    typedef struct packed
    {
        logic                wr;
        eiec_pkg::eiec_reg_e reg_id;
    } eiec_bus_s;

    eiec_bus_s st;
    eiec_bus_s next_st;
    logic      take;

    function automatic eiec_pkg::eiec_reg_e decode(input logic [31:0] a);
        eiec_pkg::eiec_reg_e r;
        r = eiec_pkg::EIEC_R_NONE;
        if (a[31:8] == 24'h000000 && a[1:0] == 2'b00)
        begin
            case (a[7:0])
                `EIEC_OFS_INT_MASK: r = eiec_pkg::EIEC_R_INT;
                `EIEC_OFS_EVT_MASK: r = eiec_pkg::EIEC_R_EVT;
                `EIEC_OFS_RISE_EN:  r = eiec_pkg::EIEC_R_RISE;
                `EIEC_OFS_FALL_EN:  r = eiec_pkg::EIEC_R_FALL;
                `EIEC_OFS_SW_TRIG:  r = eiec_pkg::EIEC_R_SW;
                `EIEC_OFS_PEND:     r = eiec_pkg::EIEC_R_PEND;
                default:            r = eiec_pkg::EIEC_R_NONE;
            endcase
        end
        return r;
    endfunction

    // hsize is not checked: only full-word transfers are issued
    assign take = hsel && hready && htrans[1];

    always_comb
    begin
        next_st        = st;
        next_st.wr     = take && hwrite;
        next_st.reg_id = decode(haddr);
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st.wr     <= 1'b0;
            st.reg_id <= eiec_pkg::EIEC_R_NONE;
        end
        else
            st <= next_st;
    end

    assign wr_en  = st.wr;
    assign wr_reg = st.reg_id;
    assign rd_en  = take && !hwrite;
    assign rd_reg = decode(haddr);

endmodule

// File: verilog/eiec_cfg.svh
`ifndef EIEC_CFG_SVH
`define EIEC_CFG_SVH

// register byte offsets
`define EIEC_OFS_INT_MASK   8'h00
`define EIEC_OFS_EVT_MASK   8'h04
`define EIEC_OFS_RISE_EN    8'h08
`define EIEC_OFS_FALL_EN    8'h0c
`define EIEC_OFS_SW_TRIG    8'h10
`define EIEC_OFS_PEND       8'h14

// channel layout
`define EIEC_NUM_LINES      19
`define EIEC_LOW_GRP_LSB    0
`define EIEC_HIGH_GRP_LSB   8
`define EIEC_GRP_WIDTH      8
`define EIEC_LINE_SVD       16
`define EIEC_LINE_AUTO_WAKE 17
`define EIEC_LINE_PDW       18

// core vector numbers of the outputs
`define EIEC_VEC_SVD        17
`define EIEC_VEC_LOW_GRP    20
`define EIEC_VEC_HIGH_GRP   33
`define EIEC_VEC_PDW        40

// reset value of every register
`define EIEC_REG_RESET      19'h00000

`endif

// File: verilog/eiec_pkg.sv
package eiec_pkg;

    typedef enum logic [1:0]
    {
        EIEC_HTRANS_IDLE   = 2'b00,
        EIEC_HTRANS_BUSY   = 2'b01,
        EIEC_HTRANS_NONSEQ = 2'b10,
        EIEC_HTRANS_SEQ    = 2'b11
    } eiec_htrans_e;

    typedef enum logic [2:0]
    {
        EIEC_R_INT  = 3'b000,
        EIEC_R_EVT  = 3'b001,
        EIEC_R_RISE = 3'b010,
        EIEC_R_FALL = 3'b011,
        EIEC_R_SW   = 3'b100,
        EIEC_R_PEND = 3'b101,
        EIEC_R_NONE = 3'b111
    } eiec_reg_e;

endpackage

// File: verilog/eiec_sync.sv
module eiec_sync
#(
    parameter int WIDTH = 19
)
(
    input  wire logic             sys_clk,   // system clock
    input  wire logic             sys_rst,   // async reset, high
    input  wire logic [WIDTH-1:0] async_in,  // raw channel inputs
    output logic      [WIDTH-1:0] level,     // filtered level
    output logic      [WIDTH-1:0] rise,      // one-cycle rising pulse
    output logic      [WIDTH-1:0] fall       // one-cycle falling pulse
);

    typedef struct packed
    {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
        logic [WIDTH-1:0] rise;
        logic [WIDTH-1:0] fall;
    } eiec_sync_s;

    eiec_sync_s st;
    eiec_sync_s next_st;

    // ----------------------------------------
    // three stages; stage one feeds only stage two
    // ----------------------------------------
    always_comb
    begin
        next_st    = st;
        next_st.s1 = async_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < WIDTH; i++)
        begin
            next_st.rise[i] = 1'b0;
            next_st.fall[i] = 1'b0;
            // accept a change only when stages two and three agree
            if (st.s2[i] == st.s3[i] && st.s3[i] != st.lvl[i])
            begin
                next_st.lvl[i]  = st.s3[i];
                next_st.rise[i] = st.s3[i];   // RQ15
                next_st.fall[i] = ~st.s3[i];  // RQ15
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign level = st.lvl;
    assign rise  = st.rise;
    assign fall  = st.fall;

    a_one_edge: assert property (@(posedge sys_clk) disable iff (sys_rst) (rise & fall) == '0) // RQ15
        else $error("rise and fall flagged together");

endmodule

// File: verilog/eiec_top.sv
// Functional notes
// RQ1: each channel detects rising, falling or both edges per its enables.
// RQ2: synchronised edge is ORed with the software trigger into one request.
// RQ3: request is ANDed separately with interrupt mask and event mask.
// RQ4: selected edge on interrupt-enabled channel sets its pending flag until cleared.
// RQ5: writing 1 clears a pending flag; writing 0 leaves it.
// RQ6: software trigger with enable set raises interrupt or event without edge.
// RQ7: event-enabled channel pulses the wake event, independent of pending flags.
// RQ8: core-side send-on-pending wake needs software to clear both pending bits.
// RQ9: channels 0-7 drive vector 20, channels 8-15 drive vector 33.
// RQ10: supply-voltage channel drives its own vector 17.
// RQ11: power-delivery wake channel drives its own vector 40.
// RQ12: six control and flag registers reached over the system bus slave.
// RQ13: nineteen channels, all enable bits reset to disabled.
// RQ14: channels 0-15 take selected port pins, 16-18 voltage, auto-wake, power wake.
// RQ15: inputs synchronised; at most one edge per clock, one flag set each.
//
// Decided for this implementation: the placing of the registers and the AHB-Lite register port.
`include "eiec_cfg.svh"

module eiec_top
#(
    parameter int LINES = `EIEC_NUM_LINES
)
(
    input  wire logic             sys_clk,       // system clock, 20 MHz
    input  wire logic             sys_rst,       // async reset, high
    input  wire logic             hsel,          // ahb slave select
    input  wire logic [31:0]      haddr,         // ahb address
    input  wire logic [1:0]       htrans,        // ahb transfer type
    input  wire logic             hwrite,        // ahb write
    input  wire logic [2:0]       hsize,         // ahb size
    input  wire logic [31:0]      hwdata,        // ahb write data
    input  wire logic             hready,        // ahb ready in
    output logic      [31:0]      hrdata,        // ahb read data
    output logic                  hreadyout,     // ahb ready out
    output logic                  hresp,         // ahb response, always okay
    input  wire logic [15:0]      port_pin,      // selected port pins, channels 0-15
    input  wire logic             supply_voltage_detect, // voltage monitor, channel 16
    input  wire logic             auto_wakeup,   // auto-wakeup source, channel 17
    input  wire logic             power_delivery_wake,   // pd wake source, channel 18
    output logic                  low_pin_group_vector,  // core vector 20 request
    output logic                  high_pin_group_vector, // core vector 33 request
    output logic                  svd_vector,    // core vector 17 request
    output logic                  pdw_vector,    // core vector 40 request
    output logic                  wake_event     // one-cycle wake for wait_for_event
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed
    {
        logic [LINES-1:0] line_int_mask;
        logic [LINES-1:0] line_event_mask;
        logic [LINES-1:0] line_rise_enable;
        logic [LINES-1:0] line_fall_enable;
        logic [LINES-1:0] sw_trigger_bits;
        logic [LINES-1:0] pend;
        logic             rd_pend;
        eiec_pkg::eiec_reg_e rd_reg;
        logic [31:0]      rdata;
        logic             vec_low;
        logic             vec_high;
        logic             vec_svd;
        logic             vec_pdw;
        logic             wake;
    } eiec_top_s;

    eiec_top_s st;
    eiec_top_s next_st;

    logic [LINES-1:0]    ch_in;
    logic [LINES-1:0]    ch_level;
    logic [LINES-1:0]    ch_rise;
    logic [LINES-1:0]    ch_fall;
    logic [LINES-1:0]    edge_req;
    logic [LINES-1:0]    comb_req;
    logic [LINES-1:0]    int_req;
    logic [LINES-1:0]    evt_req;
    logic [LINES-1:0]    sw_new;
    logic [LINES-1:0]    wdata;
    logic                wr_en;
    logic                rd_en;
    eiec_pkg::eiec_reg_e wr_reg;
    eiec_pkg::eiec_reg_e rd_reg;

    function automatic logic [31:0] widen(input logic [LINES-1:0] v);
        logic [31:0] w;
        w = '0;
        w[LINES-1:0] = v;
        return w;
    endfunction

    // ----------------------------------------
    // channel sources and synchroniser
    // ----------------------------------------
    assign ch_in = {power_delivery_wake, auto_wakeup, supply_voltage_detect, port_pin}; // RQ14

    eiec_sync
    #(
        .WIDTH (LINES)
    )
    u_sync
    (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .async_in (ch_in),
        .level    (ch_level),
        .rise     (ch_rise),
        .fall     (ch_fall)
    );

    // ----------------------------------------
    // register bus
    // ----------------------------------------
    eiec_bus u_bus
    (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .hsel    (hsel),
        .haddr   (haddr),
        .htrans  (htrans),
        .hwrite  (hwrite),
        .hsize   (hsize),
        .hready  (hready),
        .wr_en   (wr_en),
        .rd_en   (rd_en),
        .wr_reg  (wr_reg),
        .rd_reg  (rd_reg)
    );

    assign wdata = hwdata[LINES-1:0];

    // ----------------------------------------
    // request path
    // ----------------------------------------
    // a written software trigger acts in the same cycle as the write lands
    assign sw_new   = (wr_en && wr_reg == eiec_pkg::EIEC_R_SW) ? wdata : '0;
    assign edge_req = (ch_rise & st.line_rise_enable) | (ch_fall & st.line_fall_enable); // RQ1
    assign comb_req = edge_req | sw_new;                                                 // RQ2 RQ6
    assign int_req  = comb_req & st.line_int_mask;                                       // RQ3
    assign evt_req  = comb_req & st.line_event_mask;                                     // RQ3

    always_comb
    begin
        next_st = st;
        if (wr_en)
        begin
            case (wr_reg)
                eiec_pkg::EIEC_R_INT:  next_st.line_int_mask    = wdata;
                eiec_pkg::EIEC_R_EVT:  next_st.line_event_mask  = wdata;
                eiec_pkg::EIEC_R_RISE: next_st.line_rise_enable = wdata;
                eiec_pkg::EIEC_R_FALL: next_st.line_fall_enable = wdata;
                // trigger bits stay readable until the pending flag is cleared
                eiec_pkg::EIEC_R_SW:   next_st.sw_trigger_bits  = st.sw_trigger_bits | wdata;
                eiec_pkg::EIEC_R_PEND:
                begin
                    next_st.pend            = st.pend & ~wdata;            // RQ5
                    next_st.sw_trigger_bits = st.sw_trigger_bits & ~wdata;
                end
                default: next_st.pend = st.pend;
            endcase
        end
        // a new request wins over a clear in the same cycle
        next_st.pend = next_st.pend | int_req; // RQ4
        // ----------------------------------------
        // vector outputs, one request per vector group
        // ----------------------------------------
        next_st.vec_low  = |next_st.pend[`EIEC_LOW_GRP_LSB +: `EIEC_GRP_WIDTH];  // RQ9
        next_st.vec_high = |next_st.pend[`EIEC_HIGH_GRP_LSB +: `EIEC_GRP_WIDTH]; // RQ9
        next_st.vec_svd  = next_st.pend[`EIEC_LINE_SVD];                        // RQ10
        next_st.vec_pdw  = next_st.pend[`EIEC_LINE_PDW];                        // RQ11
        // the auto-wakeup channel feeds the event path and its flag only
        next_st.wake     = |evt_req;                                            // RQ7
        // ----------------------------------------
        // read data, registered in the data phase
        // ----------------------------------------
        next_st.rd_pend = rd_en;
        next_st.rd_reg  = rd_reg;
        next_st.rdata   = '0;
        if (rd_en)
        begin
            case (rd_reg)
                eiec_pkg::EIEC_R_INT:  next_st.rdata = widen(st.line_int_mask);  // RQ12
                eiec_pkg::EIEC_R_EVT:  next_st.rdata = widen(st.line_event_mask);
                eiec_pkg::EIEC_R_RISE: next_st.rdata = widen(st.line_rise_enable);
                eiec_pkg::EIEC_R_FALL: next_st.rdata = widen(st.line_fall_enable);
                eiec_pkg::EIEC_R_SW:   next_st.rdata = widen(st.sw_trigger_bits);
                eiec_pkg::EIEC_R_PEND: next_st.rdata = widen(st.pend);
                default:               next_st.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st.line_int_mask    <= `EIEC_REG_RESET; // RQ13
            st.line_event_mask  <= `EIEC_REG_RESET;
            st.line_rise_enable <= `EIEC_REG_RESET;
            st.line_fall_enable <= `EIEC_REG_RESET;
            st.sw_trigger_bits  <= `EIEC_REG_RESET;
            st.pend             <= `EIEC_REG_RESET;
            st.rd_pend          <= 1'b0;
            st.rd_reg           <= eiec_pkg::EIEC_R_NONE;
            st.rdata            <= 32'h00000000;
            st.vec_low          <= 1'b0;
            st.vec_high         <= 1'b0;
            st.vec_svd          <= 1'b0;
            st.vec_pdw          <= 1'b0;
            st.wake             <= 1'b0;
        end
        else
            st <= next_st;
    end

    // ----------------------------------------
    // outputs from flip-flops, except hreadyout and hresp, which are tied constant
    // ----------------------------------------
    assign hrdata                = st.rdata;
    assign hreadyout             = 1'b1;
    assign hresp                 = 1'b0;
    assign low_pin_group_vector  = st.vec_low;
    assign high_pin_group_vector = st.vec_high;
    assign svd_vector            = st.vec_svd;
    assign pdw_vector            = st.vec_pdw;
    assign wake_event            = st.wake;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // a flag may only rise after an enabled edge or a software trigger on a masked-in channel
    a_edge_select: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ1
        ##1 ((st.pend & ~$past(st.pend) & ~$past(st.line_int_mask & (sw_new
            | (ch_rise & st.line_rise_enable) | (ch_fall & st.line_fall_enable)))) == '0))
        else $error("flag set without enabled edge");
    a_flag_set: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ4
        (int_req != '0) |=> ((st.pend & $past(int_req)) == $past(int_req)))
        else $error("pending flag not set by request");
    a_flag_hold: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ5
        !(wr_en && wr_reg == eiec_pkg::EIEC_R_PEND) |=> ((st.pend & $past(st.pend)) == $past(st.pend)))
        else $error("pending flag lost without clear");
    a_flag_clear: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ5
        (wr_en && wr_reg == eiec_pkg::EIEC_R_PEND && int_req == '0) |=> ((st.pend & $past(wdata)) == '0))
        else $error("write one did not clear flag");
    a_sw_int: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ6
        (wr_en && wr_reg == eiec_pkg::EIEC_R_SW && (wdata & st.line_int_mask) != '0)
        |=> ((st.pend & $past(wdata & st.line_int_mask)) != '0))
        else $error("software trigger raised no interrupt");
    a_wake_evt: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ7
        (evt_req != '0) |=> wake_event ##1 (!wake_event || $past(evt_req != '0)))
        else $error("event did not pulse wake");
    a_vec_low: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ9
        ##1 low_pin_group_vector == |st.pend[7:0])
        else $error("low group vector mismatch");
    a_vec_high: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ9
        ##1 high_pin_group_vector == |st.pend[15:8])
        else $error("high group vector mismatch");
    a_vec_svd: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ10
        svd_vector == st.pend[16])
        else $error("voltage vector mismatch");
    a_vec_pdw: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ11
        pdw_vector == st.pend[18])
        else $error("power wake vector mismatch");
    a_read_data: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ12
        (rd_en && rd_reg == eiec_pkg::EIEC_R_INT) |=> (hrdata == widen($past(st.line_int_mask))))
        else $error("read of interrupt mask wrong");

    c_pin_int:  cover property (@(posedge sys_clk) disable iff (sys_rst) int_req[0] ##1 low_pin_group_vector);
    c_sw_event: cover property (@(posedge sys_clk) disable iff (sys_rst) (sw_new != '0) ##1 wake_event);
    c_clear:    cover property (@(posedge sys_clk) disable iff (sys_rst)
        high_pin_group_vector ##1 (wr_en && wr_reg == eiec_pkg::EIEC_R_PEND) ##1 !high_pin_group_vector);
    c_pdw:      cover property (@(posedge sys_clk) disable iff (sys_rst) pdw_vector);

endmodule
